// ===== inc/hdl_pkg.sv
// Package for the codec-side audio link port: constants and carriers
package hdl_pkg;

  // ==========================================================
  // Link timing and frame format
  localparam int unsigned BIT_CLOCK_KHZ    = 24000;
  localparam int unsigned FRAME_BITS       = 500;
  localparam int unsigned FRAME_CNT_W      = 9;
  localparam int unsigned OUT_CNT_W        = 10;
  localparam int unsigned TAG_BITS         = 4;
  localparam int unsigned IN_WORD_BITS     = 16;
  localparam int unsigned OUT_WORD_BITS    = 16;
  localparam logic [3:0]  OWN_STREAM_RST   = 4'h1;
  localparam logic [8:0]  FRAME_LAST       = 9'h1f3;
  localparam logic [8:0]  FRAME_CNT_RST    = 9'h000;
  localparam logic [9:0]  OUT_CNT_RST      = 10'h000;

  // ==========================================================
  // Link-side state
  typedef enum logic [1:0] {
    HDL_ST_RESET = 2'b00,
    HDL_ST_HUNT  = 2'b01,
    HDL_ST_RUN   = 2'b10
  } hdl_link_st_t;

  typedef struct packed {
    logic [OUT_WORD_BITS-1:0] data;
    logic [TAG_BITS-1:0]      tag;
  } hdl_out_word_t;

endpackage : hdl_pkg

// ===== src/hdl_sync2.sv
// Two-flop level synchroniser into the system clock domain
`timescale 1ns/1ps
module hdl_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } hdl_sync_state_t;

  hdl_sync_state_t st_reg;
  hdl_sync_state_t st_next;

  always_comb begin
    st_next.meta = d_in;
    st_next.q    = st_reg.meta;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_out = st_reg.q;
endmodule : hdl_sync2

// ===== src/hdl_link_port.sv
// Codec-side port of the high definition audio serial link
// Function
// - Bit clock from controller times link logic
// - Link reset low returns link logic default
// - Sync locates inbound and outbound frame boundaries
// - Sync stream tag selects our outbound data
// - Inbound data driven one bit per clock
// - Outbound data sampled on both edges
`timescale 1ns/1ps
module hdl_link_port (
  input  wire logic                          clk_in,
  input  wire logic                          sys_rst_in,
  input  wire logic                          link_bit_clock_pin,
  input  wire logic                          link_reset_n_pin,
  input  wire logic                          link_frame_sync_pin,
  input  wire logic                          link_outbound_serial_pin,
  output logic                               link_inbound_serial_pin_out,
  output logic                               link_inbound_serial_oe_n_out,
  input  wire logic [hdl_pkg::TAG_BITS-1:0]  own_stream_in,
  input  wire logic [hdl_pkg::IN_WORD_BITS-1:0] in_word_in,
  output logic                               in_word_ready_out,
  output hdl_pkg::hdl_out_word_t             out_word_out,
  output logic                               out_word_valid_out,
  output logic                               link_running_out
);
  // ==========================================================
  // Link domain: all state on the controller bit clock
  typedef struct packed {
    hdl_pkg::hdl_link_st_t                 st;
    logic                                  sync_d;
    logic [hdl_pkg::FRAME_CNT_W-1:0]       bit_cnt;
    logic [hdl_pkg::TAG_BITS-1:0]          tag_sh;
    logic [hdl_pkg::TAG_BITS-1:0]          tag;
    logic [hdl_pkg::OUT_CNT_W-1:0]         out_cnt;
    logic [hdl_pkg::OUT_WORD_BITS-1:0]     out_sh;
    hdl_pkg::hdl_out_word_t                out_word;
    logic                                  out_tgl;
    logic [hdl_pkg::IN_WORD_BITS-1:0]      in_sh;
    logic                                  in_tgl;
    logic                                  sdi;
    logic                                  oe_n;
  } hdl_link_state_t;

  hdl_link_state_t lk_reg;
  hdl_link_state_t lk_next;
  logic            neg_bit_reg;
  logic            frame_start;
  logic            own_slot;
  // Quasi-static or held words from the other domain; the held word is read only at reload
  logic [hdl_pkg::TAG_BITS-1:0]     own_stream_sync;
  logic [hdl_pkg::IN_WORD_BITS-1:0] in_word_hold;

  // Falling-edge sample of the outbound line; paired with the rising one
  always_ff @(negedge link_bit_clock_pin or negedge link_reset_n_pin) begin
    if (!link_reset_n_pin) begin
      neg_bit_reg <= 1'b0;
    end else begin
      neg_bit_reg <= link_outbound_serial_pin;
    end
  end

  // Sync is held high for the last bits of a frame; falling edge is the start.
  // Tag bits on sync fall too, so in run a start is only taken past the tag field.
  assign frame_start = lk_reg.sync_d && !link_frame_sync_pin &&
                       (lk_reg.st != hdl_pkg::HDL_ST_RUN || lk_reg.bit_cnt > 9'h004);
  // Tag zero marks a frame with no stream in it
  assign own_slot    = (lk_reg.tag == own_stream_sync) && (lk_reg.tag != '0);

  always_comb begin
    lk_next        = lk_reg;
    lk_next.sync_d = link_frame_sync_pin;
    lk_next.bit_cnt = frame_start ? hdl_pkg::FRAME_CNT_RST
                    : lk_reg.bit_cnt + 9'h001;
    // Tag is shifted in on sync for the first four bits after frame start
    if (lk_reg.bit_cnt < 9'h004) begin
      lk_next.tag_sh = {lk_reg.tag_sh[hdl_pkg::TAG_BITS-2:0], link_frame_sync_pin};
    end
    if (lk_reg.bit_cnt == 9'h004) begin
      lk_next.tag     = lk_reg.tag_sh;
      lk_next.out_cnt = hdl_pkg::OUT_CNT_RST;
    end
    if (own_slot && lk_reg.st == hdl_pkg::HDL_ST_RUN) begin
      // Two bits per clock: falling-edge bit came first
      lk_next.out_sh  = {lk_reg.out_sh[hdl_pkg::OUT_WORD_BITS-3:0], neg_bit_reg,
                         link_outbound_serial_pin};
      // Word count restarts with the tag so words line up with the frame
      lk_next.out_cnt = (lk_reg.bit_cnt == 9'h004) ? hdl_pkg::OUT_CNT_RST
                      : lk_reg.out_cnt + 10'h002;
      if (lk_reg.out_cnt[3:0] == 4'he) begin
        lk_next.out_word.data = {lk_reg.out_sh[hdl_pkg::OUT_WORD_BITS-3:0], neg_bit_reg,
                                 link_outbound_serial_pin};
        lk_next.out_word.tag  = lk_reg.tag;
        lk_next.out_tgl       = !lk_reg.out_tgl;
      end
    end
    case (lk_reg.st)
      hdl_pkg::HDL_ST_RESET: begin
        lk_next.oe_n = 1'b1;
        lk_next.st   = hdl_pkg::HDL_ST_HUNT;
      end
      hdl_pkg::HDL_ST_HUNT: begin
        lk_next.oe_n = 1'b1;
        if (frame_start) begin
          lk_next.st = hdl_pkg::HDL_ST_RUN;
        end
      end
      hdl_pkg::HDL_ST_RUN: begin
        lk_next.oe_n = 1'b0;
        // Shift out one inbound bit per clock, new word at every 16 bits
        if (frame_start || lk_reg.bit_cnt[3:0] == 4'hf) begin
          lk_next.in_sh  = in_word_hold;
          lk_next.in_tgl = !lk_reg.in_tgl;
        end else begin
          lk_next.in_sh = {lk_reg.in_sh[hdl_pkg::IN_WORD_BITS-2:0], 1'b0};
        end
        lk_next.sdi = lk_reg.in_sh[hdl_pkg::IN_WORD_BITS-1];
      end
      default: begin
        lk_next.st = hdl_pkg::HDL_ST_RESET;
      end
    endcase
  end

  // Asynchronous entry to reset, so the link resets even without a clock
  always_ff @(posedge link_bit_clock_pin or negedge link_reset_n_pin) begin
    if (!link_reset_n_pin) begin
      lk_reg      <= '0;
      lk_reg.st   <= hdl_pkg::HDL_ST_RESET;
      lk_reg.oe_n <= 1'b1;
    end else begin
      lk_reg <= lk_next;
    end
  end

  // Inbound line may only drive in run state; the controller's pull-down
  // holds it low otherwise
  assign link_inbound_serial_pin_out  = lk_reg.sdi & ~lk_reg.oe_n;
  assign link_inbound_serial_oe_n_out = lk_reg.oe_n;

  // ==========================================================
  // Crossing: words are held stable across a toggle handshake
  // Both toggles and the run bit pass one shared two-flop synchroniser
  logic [2:0]                       cross_sys;
  logic                             in_tgl_sys;
  logic                             out_tgl_sys;
  logic                             run_sys;

  // Own stream number is quasi-static; two flops on the link side
  logic [hdl_pkg::TAG_BITS-1:0] own_meta_reg;
  logic [hdl_pkg::TAG_BITS-1:0] own_stream_sync_reg;
  always_ff @(posedge link_bit_clock_pin or negedge link_reset_n_pin) begin
    if (!link_reset_n_pin) begin
      own_meta_reg        <= hdl_pkg::OWN_STREAM_RST;
      own_stream_sync_reg <= hdl_pkg::OWN_STREAM_RST;
    end else begin
      own_meta_reg        <= own_stream_in;
      own_stream_sync_reg <= own_meta_reg;
    end
  end
  assign own_stream_sync = own_stream_sync_reg;

  hdl_sync2 #(.W(3)) u_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .d_in       ({lk_reg.in_tgl, lk_reg.out_tgl, lk_reg.st == hdl_pkg::HDL_ST_RUN}),
    .q_out      (cross_sys)
  );
  assign {in_tgl_sys, out_tgl_sys, run_sys} = cross_sys;

  // ==========================================================
  // System domain
  typedef struct packed {
    logic                             in_tgl_d;
    logic                             out_tgl_d;
    logic [hdl_pkg::IN_WORD_BITS-1:0] in_hold;
    hdl_pkg::hdl_out_word_t           out_word;
    logic                             out_valid;
    logic                             ready;
    logic                             run;
  } hdl_sys_state_t;

  hdl_sys_state_t sy_reg;
  hdl_sys_state_t sy_next;

  always_comb begin
    sy_next           = sy_reg;
    sy_next.in_tgl_d  = in_tgl_sys;
    sy_next.out_tgl_d = out_tgl_sys;
    sy_next.run       = run_sys;
    sy_next.out_valid = 1'b0;
    sy_next.ready     = 1'b0;
    // A link reset zeroes both toggles; gating on run keeps that from
    // looking like a transfer
    // Link took the held word: accept the next one from the user
    if (run_sys && in_tgl_sys != sy_reg.in_tgl_d) begin
      sy_next.in_hold = in_word_in;
      sy_next.ready   = 1'b1;
    end
    // Link word was written with the toggle and stays stable for eight link clocks after it
    if (run_sys && out_tgl_sys != sy_reg.out_tgl_d) begin
      sy_next.out_word  = lk_reg.out_word;
      sy_next.out_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sy_reg <= '0;
    end else begin
      sy_reg <= sy_next;
    end
  end

  assign in_word_hold       = sy_reg.in_hold;
  assign in_word_ready_out  = sy_reg.ready;
  assign out_word_out       = sy_reg.out_word;
  assign out_word_valid_out = sy_reg.out_valid;
  assign link_running_out   = sy_reg.run;
endmodule : hdl_link_port

// ===== bench/hdl_link_port_checker.sv
// Concurrent checks on the audio link port
`timescale 1ns/1ps
module hdl_link_port_checker (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic link_bit_clock_pin,
  input wire logic link_reset_n_pin,
  input wire logic link_frame_sync_pin,
  input wire logic link_outbound_serial_pin,
  input wire logic link_inbound_serial_pin_out,
  input wire logic link_inbound_serial_oe_n_out,
  input wire logic [3:0] own_stream_in,
  input wire logic [15:0] in_word_in,
  input wire logic in_word_ready_out,
  input wire hdl_pkg::hdl_out_word_t out_word_out,
  input wire logic out_word_valid_out,
  input wire logic link_running_out
);
  // =====
  // Pulse spacing, tags and the inbound pin
  wire lclk = link_bit_clock_pin;
  wire lrst = !link_reset_n_pin;
  wire oe_n = link_inbound_serial_oe_n_out;
  wire sync = link_frame_sync_pin;
  sequence quiet8;
    !out_word_valid_out [*8];
  endsequence
  sequence ready_gap;
    !in_word_ready_out [*4];
  endsequence
  chk_word_gap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    out_word_valid_out |=> quiet8) else $error("out words too close");
  chk_reload_gap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    in_word_ready_out |=> ready_gap) else $error("reloads too close");
  chk_tag_own: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    out_word_valid_out |-> out_word_out.tag == own_stream_in) else $error("foreign tag");
  chk_sys_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> !out_word_valid_out && !link_running_out) else $error("busy after reset");
  chk_run_needs_link: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    lrst [*8] |=> !link_running_out) else $error("running in link reset");
  chk_idle_low: assert property (@(posedge lclk) disable iff (lrst)
    oe_n |-> !link_inbound_serial_pin_out) else $error("idle pin high");
  chk_release_quiet: assert property (@(posedge lclk) disable iff (lrst)
    $rose(link_reset_n_pin) |-> oe_n) else $error("driven at release");
  chk_drive_after_sync: assert property (@(posedge lclk) disable iff (lrst)
    $fell(oe_n) |-> $past(sync, 2) || $past(sync, 3) || $past(sync, 4)) else $error("driven without sync");
endmodule : hdl_link_port_checker

// ===== bench/hdl_ctrl_model.sv
// Behavioural controller at the far end of the link
`timescale 1ns/1ps
module hdl_ctrl_model (
  input wire logic en_in,
  input wire logic rst_req_n_in,
  input wire logic [3:0] tag_in,
  input wire logic sdi_in,
  input wire logic oe_n_in,
  output logic bclk_out,
  output logic rst_n_out,
  output logic sync_out,
  output logic sdo_out,
  output logic hit_out
);
  // =====
  // Frames, tags and double-pumped data
  logic [8:0] cnt_reg;
  logic [15:0] sh_reg;
  wire sdi_line = oe_n_in ? 1'b0 : sdi_in;
  initial begin
    rst_n_out = 1'b0;
    bclk_out = 1'b0;
    #1.3;
    forever #3 bclk_out = ~bclk_out;
  end
  always @(posedge bclk_out) begin
    rst_n_out <= rst_req_n_in;
    sdo_out <= 1'b1;
    sh_reg <= {sh_reg[14:0], sdi_line};
    hit_out <= rst_n_out && (hit_out || (sh_reg == 16'hc3a5 && !oe_n_in));
    if (!rst_n_out || !en_in) begin
      cnt_reg <= 9'h000;
      sync_out <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == hdl_pkg::FRAME_LAST) ? 9'h000 : cnt_reg + 9'h001;
      sync_out <= cnt_reg == 9'h000 || (cnt_reg inside {[9'h002:9'h005]} && tag_in[3'h5 - cnt_reg[2:0]]);
    end
  end
  // Rising-edge bit low, falling-edge bit high: a word reads alternating ones
  always @(negedge bclk_out) sdo_out <= 1'b0;
endmodule : hdl_ctrl_model

// ===== bench/tb.sv
// Self-checking bench for the audio link port
`timescale 1ns/1ps
module tb;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic en = 1'b0;
  logic rst_req_n = 1'b0;
  logic [3:0] tag = 4'h1;
  logic [3:0] own_stream_in = 4'h1;
  logic [15:0] in_word_in = 16'hc3a5;
  wire link_bit_clock_pin, link_reset_n_pin, link_frame_sync_pin, link_outbound_serial_pin, hit;
  logic link_inbound_serial_pin_out, link_inbound_serial_oe_n_out;
  logic in_word_ready_out, out_word_valid_out, link_running_out;
  hdl_pkg::hdl_out_word_t out_word_out, last_word;
  int n_errors = 0;
  int num_checks = 0;
  int n_valid = 0;
  int n_ready = 0;
  // =====
  // Clock, instances and pulse counters
  always #2 clk_in = ~clk_in;
  hdl_link_port hdl_link_port_i (
    .clk_in                       (clk_in),
    .sys_rst_in                   (sys_rst_in),
    .link_bit_clock_pin           (link_bit_clock_pin),
    .link_reset_n_pin             (link_reset_n_pin),
    .link_frame_sync_pin          (link_frame_sync_pin),
    .link_outbound_serial_pin     (link_outbound_serial_pin),
    .link_inbound_serial_pin_out  (link_inbound_serial_pin_out),
    .link_inbound_serial_oe_n_out (link_inbound_serial_oe_n_out),
    .own_stream_in                (own_stream_in),
    .in_word_in                   (in_word_in),
    .in_word_ready_out            (in_word_ready_out),
    .out_word_out                 (out_word_out),
    .out_word_valid_out           (out_word_valid_out),
    .link_running_out             (link_running_out)
  );
  hdl_ctrl_model hdl_ctrl_model_i (.en_in(en), .rst_req_n_in(rst_req_n), .tag_in(tag),
    .sdi_in(link_inbound_serial_pin_out), .oe_n_in(link_inbound_serial_oe_n_out), .bclk_out(link_bit_clock_pin),
    .rst_n_out(link_reset_n_pin), .sync_out(link_frame_sync_pin), .sdo_out(link_outbound_serial_pin), .hit_out(hit));
  always @(posedge clk_in) begin
    if (out_word_valid_out === 1'b1)
      last_word <= out_word_out;
    n_valid <= n_valid + int'(out_word_valid_out === 1'b1);
    n_ready <= n_ready + int'(in_word_ready_out === 1'b1);
  end
  task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic wait_run;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_in);
      if (link_running_out === 1'b1)
        return;
    end
    n_errors++;
    wrap_up();
  endtask : wait_run
  task automatic t_reset_idle;
    repeat (20) @(posedge clk_in);
    check("oe_n", 1, link_inbound_serial_oe_n_out);
    check("sdi", 0, link_inbound_serial_pin_out);
    check("running", 0, link_running_out);
  endtask : t_reset_idle
  task automatic t_own;
    rst_req_n <= 1'b1;
    en <= 1'b1;
    wait_run();
    repeat (1600) @(posedge clk_in);
    check("words", 1, n_valid > 1);
    check("data", 16'haaaa, last_word.data);
    check("tag", 4'h1, last_word.tag);
    check("inbound", 1, hit);
    check("reloads", 1, n_ready > 1);
  endtask : t_own
  // Stream number changes only under link reset, so no word in flight carries a stale tag
  task automatic t_tags;
    int k;
    logic [3:0] tags [3] = '{4'h0, 4'h3, 4'ha};
    foreach (tags[i]) begin
      rst_req_n <= 1'b0;
      repeat (20) @(posedge clk_in);
      check("oe_n", 1, link_inbound_serial_oe_n_out);
      check("running", 0, link_running_out);
      own_stream_in <= 4'ha;
      tag <= tags[i];
      rst_req_n <= 1'b1;
      wait_run();
      k = n_valid;
      repeat (1600) @(posedge clk_in);
      check("own words", tags[i] == 4'ha, n_valid > k);
    end
  endtask : t_tags
  initial begin
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset_idle();
    t_own();
    t_tags();
    wrap_up();
  end
endmodule : tb
bind hdl_link_port hdl_link_port_checker hdl_link_port_checker_i (.*);
